// >>> dv/pus_host_model.sv
// Host side of the power-on pin: raises it (level mode) or pulls it low
// and keeps it there past the debounce time (edge mode).
// Assumes the bench drives go and edge_mode from pclk.
`timescale 1ns/1ps
module pus_host_model (
    // Clock
    input  wire logic pclk,
    // Bench control
    input  wire logic go,
    input  wire logic edge_mode,
    // Pin towards the device
    output logic      power_on_pin
);
    // ==========================================================
    // Pin driver
    // Edge mode drives the pin as go inverted: low for as long as go stays high
    always @(posedge pclk)
    begin
        power_on_pin <= edge_mode ? !go : go;
    end
endmodule : pus_host_model

// >>> dv/pus_seq_tb.sv
// Self-checking bench of the power-up sequencer, with shortened counts.
// Assumes the register map of pus_regs.svh and zero-wait APB.
`timescale 1ns/1ps
`include "pus_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module pus_seq_tb;
    import pus_pkg::*;
    // ==========================================================
    // Shortened counts handed to the design
    localparam int BIAS = 20, FUSE = 10, STEST = 10, DBNC = 8;
    localparam int T0 = 4, T1 = 6, T2 = 8, T3 = 10;
    localparam int BOOT = BIAS + FUSE + STEST + 8; // Worst start of slot one
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        power_on_pin, mode_fuse, go, err;
    logic        sw_en, ldo_en, power_good_output, host_reset_output_n, seq_done;
    pus_fuse_s   fuse;
    pus_qual_s   qual;
    int          error_cnt, comparisons, c1, c2;
    // ==========================================================
    // Clock and instances
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    pus_host_model u_host (.pclk(pclk), .go(go), .edge_mode(mode_fuse),
        .power_on_pin(power_on_pin));
    pus_seq #(.BIAS_CYC(BIAS), .FUSE_CYC(FUSE), .STEST_CYC(STEST), .DBNC_CYC(DBNC),
        .TB0_CYC(T0), .TB1_CYC(T1), .TB2_CYC(T2), .TB3_CYC(T3)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_on_pin(power_on_pin),
        .power_on_pin_mode_fuse(mode_fuse), .fuse(fuse), .qual(qual),
        .sw_en(sw_en), .ldo_en(ldo_en), .power_good_output(power_good_output),
        .host_reset_output_n(host_reset_output_n), .seq_done(seq_done));
    // ==========================================================
    // Shared tasks
    task finish_test;
        $display("Checks %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    // One APB transfer; held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin error_cnt++; finish_test(); end
    endtask : apb
    // Cycles until a chosen output is high; a hang ends the run
    task wait_out(input int sel, output int cyc);
        cyc = 0;
        while (!((sel == 0) ? sw_en === 1'b1 : (sel == 1) ? ldo_en === 1'b1 :
                 (sel == 2) ? host_reset_output_n === 1'b1 : seq_done === 1'b1)) begin
            @(posedge pclk);
            cyc++;
            if (cyc > 3000) begin error_cnt++; finish_test(); end
        end
    endtask : wait_out
    // Fresh supply crossing with given fuses and pin mode
    task start(input logic m, input pus_fuse_s f, input logic [7:0] q, input logic g);
        mode_fuse <= m; fuse <= f; qual <= q; go <= g; presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : start
    // ==========================================================
    // Scenarios
    // Level mode, pin already high, unslotted reset, ovlo without shutdown fuse
    task s_level;
        start(1'b0, '{tbase:2'h0, sw_slot:8'h01, ldo_slot:8'h03, pg_slot:8'h02,
              rst_slot:8'h00}, 8'he0, 1'b1);
        wait_out(0, c1);
        `CHK("boot", 1'b1, c1 <= BOOT)
        wait_out(1, c2);
        `CHK("ldo_gap", 2 * T0, c2)
        `CHK("pg_order", 1'b1, power_good_output)
        `CHK("rst_early", 1'b0, host_reset_output_n)
        wait_out(2, c1);
        wait_out(3, c2);
        `CHK("done", 1'b1, c2 <= T0 + 2)
        apb(1'b0, `PUS_SLOT_OFF, 32'h0);
        `CHK("slot", 32'h00020301, rd)
        apb(1'b0, `PUS_CTRL_OFF, 32'h0);
        `CHK("lpoff_rst", 32'h0, rd)
        apb(1'b1, `PUS_CTRL_OFF, 32'h1);
        apb(1'b1, `PUS_TBASE_OFF, 32'h3);
        apb(1'b0, `PUS_CTRL_OFF, 32'h0);
        `CHK("lpoff_wr", 32'h1, rd)
        apb(1'b0, 12'h014, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("unmapped_err", 1'b1, err)
        start(1'b0, '{tbase:2'h2, default:8'h00}, 8'h80, 1'b0);
        repeat (BIAS + FUSE + 4) @(posedge pclk);
        apb(1'b0, `PUS_TBASE_OFF, 32'h0);
        `CHK("tbase_reload", 32'h2, rd)
        apb(1'b0, `PUS_CTRL_OFF, 32'h0);
        `CHK("lpoff_clr", 32'h0, rd)
    endtask : s_level
    // Edge mode gives the same slot spacing once the event is seen
    task s_edge;
        start(1'b1, '{tbase:2'h1, sw_slot:8'h01, ldo_slot:8'h03, pg_slot:8'h00,
              rst_slot:8'h00}, 8'h80, 1'b0);
        repeat (BOOT + 10) @(posedge pclk);
        `CHK("no_event", 1'b0, sw_en)
        go <= 1'b1;
        wait_out(0, c1);
        wait_out(1, c2);
        `CHK("edge_gap", 2 * T1, c2)
        `CHK("pg_off", 1'b0, power_good_output)
    endtask : s_edge
    // Thermal and overvoltage shutdown both refuse the event
    task s_refuse;
        logic [7:0] q [2] = '{8'h88, 8'hf0};
        foreach (q[i]) begin
            start(1'b0, '{tbase:2'h0, sw_slot:8'h01, ldo_slot:8'h00, pg_slot:8'h00,
                  rst_slot:8'h00}, q[i], 1'b1);
            repeat (BOOT + 40) @(posedge pclk);
            `CHK("refused", 2'b00, {sw_en, host_reset_output_n})
        end
    endtask : s_refuse
    // All slots empty: run with nothing on, reset released
    task s_slave;
        start(1'b0, '{tbase:2'h0, sw_slot:8'h00, ldo_slot:8'h00, pg_slot:8'h00,
              rst_slot:8'h00}, 8'h80, 1'b1);
        wait_out(2, c1);
        wait_out(3, c2);
        `CHK("slave_outs", 3'b000, {sw_en, ldo_en, power_good_output})
        apb(1'b1, `PUS_STAT_OFF, 32'h1);
        apb(1'b1, `PUS_CTRL_OFF, 32'h2);
        `CHK("bypass_clr", 1'b0, seq_done)
        apb(1'b1, `PUS_CTRL_OFF, 32'h0);
        wait_out(3, c1);
        `CHK("bypass_done", 1'b1, c1 <= 2)
    endtask : s_slave
    // Standby and back with a new time base
    task s_standby;
        start(1'b0, '{tbase:2'h0, sw_slot:8'h01, ldo_slot:8'h03, pg_slot:8'h00,
              rst_slot:8'h00}, 8'h80, 1'b1);
        wait_out(3, c1);
        apb(1'b1, `PUS_TBASE_OFF, 32'h2);
        apb(1'b1, `PUS_STAT_OFF, 32'h1);
        apb(1'b1, `PUS_CTRL_OFF, 32'h2);
        repeat (5) @(posedge pclk);
        `CHK("stby_off", 3'b000, {sw_en, ldo_en, seq_done})
        apb(1'b1, `PUS_CTRL_OFF, 32'h0);
        wait_out(0, c1);
        wait_out(1, c2);
        `CHK("stby_gap", 2 * T2, c2)
        wait_out(3, c1);
        `CHK("stby_done", 1'b1, seq_done)
    endtask : s_standby
    // ==========================================================
    // Main sequence
    initial
    begin
        error_cnt = 0; comparisons = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; go = 1'b0; mode_fuse = 1'b0;
        fuse = '0; qual = 8'h80;
        s_level();
        s_edge();
        s_refuse();
        s_slave();
        s_standby();
        finish_test();
    end
endmodule : pus_seq_tb

// >>> rtl/pus_pkg.sv
// Types of the power-up sequencer.
// Assumes nothing of its surroundings.
package pus_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        PUS_ST_OFF   = 3'b000,
        PUS_ST_FUSE  = 3'b001,
        PUS_ST_LPOFF = 3'b010,
        PUS_ST_STEST = 3'b011,
        PUS_ST_SEQ   = 3'b100,
        PUS_ST_RUN   = 3'b101,
        PUS_ST_STBY  = 3'b110
    } pus_state_e;

    // Qualification inputs for a power-up event
    typedef struct packed {
        logic uv_ok;
        logic ov_det;
        logic ov_en;
        logic ov_sdwn_fuse;
        logic tsd;
        logic trim_load_failed;
        logic fuse_load_failed;
        logic self_test_failed;
    } pus_qual_s;

    // Fuse image loaded on each pass through an off mode
    typedef struct packed {
        logic [1:0] tbase;
        logic [7:0] sw_slot;
        logic [7:0] ldo_slot;
        logic [7:0] pg_slot;
        logic [7:0] rst_slot;
    } pus_fuse_s;

endpackage : pus_pkg

// >>> rtl/pus_regs.svh
// Constants for the power-up sequencer: register offsets, field positions,
// reset values and timing counts.
// Assumes a 250 MHz pclk; included by its bare name.
`ifndef PUS_REGS_SVH
`define PUS_REGS_SVH

// ==========================================================
// Register byte offsets
`define PUS_CTRL_OFF      12'h000
`define PUS_STAT_OFF      12'h004
`define PUS_TBASE_OFF     12'h008
`define PUS_SLOT_OFF      12'h00c
`define PUS_STBY_OFF      12'h010

// ==========================================================
// Field positions
`define PUS_CTRL_LPOFF    0
`define PUS_CTRL_STBY     1
`define PUS_STAT_DONE     0
`define PUS_STAT_RUN      1
`define PUS_STAT_STESTOK  2

// ==========================================================
// Reset values
`define PUS_CTRL_RST      2'h0

// ==========================================================
// Timing, in ns and in cycles (4 ns period)
`define PUS_CLK_NS        4
`define PUS_BIAS_MAX_NS   1500000
`define PUS_STEST_MAX_NS  1400000
`define PUS_FIRST_MAX_NS  100000
`define PUS_FUSE_MAX_NS   600000
`define PUS_LPM_MAX_NS    700000
`define PUS_FIRST_CYC     (`PUS_FIRST_MAX_NS / `PUS_CLK_NS)
`define PUS_TB0_NS        30000
`define PUS_TB1_NS        120000
`define PUS_TB2_NS        250000
`define PUS_TB3_NS        500000

`endif

// >>> rtl/pus_seq.sv
`timescale 1ns/1ps
// Power-up sequencer: startup, event qualification, slot sequencing, run/standby.
// Assumes all inputs synchronous to pclk; presetn models the supply crossing.
// Overview of operation
// RULE1: Bias done, sequence begins within 1.5 ms
// RULE2: Self-test done within 1.4 ms, pin high
// RULE3: First slot within 100 us of self-test
// RULE4: Slots should release host reset early
// RULE5: Turn-on timing same in level, edge modes
// RULE6: Supply crossing clears low-power-off select
// RULE7: Fuse load 600 us, low-power mode 700 us
// RULE8: Low-power-off select writable in run
// RULE9: Event is level or debounced falling edge
// RULE10: Event needs supply, temperature, failure flags ok
// RULE11: Time base from fuse, writable when on
// RULE12: Time base codes 30/120/250/500 us
// RULE13: Slot code zero excludes the output
// RULE14: Code one immediate, codes step by base
// RULE15: Unslotted host reset follows last regulator
// RULE16: All unslotted enters run, releases reset
// RULE17: Done flag after last slot ends
// RULE18: Standby exit sequences only on re-enable
// RULE19: Done flag after every standby exit
// RULE20: Delay system rails for always-on supply
// RULE21: Slots from fuses, functional copies writable
// RULE22: Off mode reloads fuse values
// RULE23: Equal slots same edge, ascending order
`include "pus_regs.svh"
module pus_seq
    import pus_pkg::*;
#(
    parameter int BIAS_CYC  = 1000,       // Core bias time, within 1.5 ms
    parameter int FUSE_CYC  = 1000,       // Fuse load, within 600 us
    parameter int STEST_CYC = 1000,       // Self-test, within 1.4 ms
    parameter int DBNC_CYC  = 1000,       // Power-on debounce time
    parameter int TB0_CYC   = `PUS_TB0_NS / `PUS_CLK_NS,
    parameter int TB1_CYC   = `PUS_TB1_NS / `PUS_CLK_NS,
    parameter int TB2_CYC   = `PUS_TB2_NS / `PUS_CLK_NS,
    parameter int TB3_CYC   = `PUS_TB3_NS / `PUS_CLK_NS
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Power-on pin and fuses
    input  wire logic        power_on_pin,
    input  wire logic        power_on_pin_mode_fuse,
    input  wire pus_fuse_s   fuse,
    input  wire pus_qual_s   qual,
    // Outputs
    output logic             sw_en,
    output logic             ldo_en,
    output logic             power_good_output,
    output logic             host_reset_output_n,
    output logic             seq_done
);

    // ==========================================================
    // Declarations
    pus_state_e  state_r, state_nxt;      // Main state
    logic [31:0] cnt_r;                   // Phase timer
    logic [31:0] tb_cnt_r;                // Slot timer
    logic [7:0]  slot_r;                  // Slot code in progress
    logic        tick;                    // Slot boundary
    logic        low_power_off_r;         // Low-power-off select
    logic        stby_req_r;              // Software standby request
    logic [1:0]  sequencer_time_base_r;
    logic [7:0]  switcher_slot_r, linear_regulator_slot_r;
    logic [7:0]  power_good_output_slot_r, host_reset_slot_r;
    logic [7:0]  last_slot;               // Highest of the four slot codes
    logic        pin_d_r;                 // Pin history
    logic        pin_low_r;               // Falling edge seen
    logic [31:0] dbnc_r;                  // Debounce counter
    logic        event_raw, event_ok;
    logic        stest_ok_r;
    logic        rst_rel_r;               // Unslotted reset release
    logic [31:0] tb_cyc;
    logic        wr_en;
    logic        sw_en_i, ldo_en_i, pg_i, rst_i;
    logic        stby_was_on_r;           // Rails cut in standby

    // ==========================================================
    // Time base decode
    always_comb
    begin
        case (sequencer_time_base_r)      // RULE12
            2'b00:   tb_cyc = TB0_CYC;
            2'b01:   tb_cyc = TB1_CYC;
            2'b10:   tb_cyc = TB2_CYC;
            default: tb_cyc = TB3_CYC;
        endcase
    end

    // Last sequenced slot; host reset counted so a late reset slot is still reached
    always_comb
    begin
        last_slot = switcher_slot_r;
        if (linear_regulator_slot_r > last_slot)
            last_slot = linear_regulator_slot_r;
        if (power_good_output_slot_r > last_slot)
            last_slot = power_good_output_slot_r;
        if (host_reset_slot_r > last_slot)
            last_slot = host_reset_slot_r;
    end

    // ==========================================================
    // Power-up event detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_d_r   <= 1'b0;
            pin_low_r <= 1'b0;
            dbnc_r    <= '0;
        end
        else
        begin
            pin_d_r <= power_on_pin;
            if (power_on_pin)
            begin
                pin_low_r <= 1'b0;
                dbnc_r    <= '0;
            end
            else if (pin_d_r)
                pin_low_r <= 1'b1;        // Falling edge seen
            else if (pin_low_r && dbnc_r < DBNC_CYC)
                dbnc_r <= dbnc_r + 32'h1;
        end
    end

    // Level mode or debounced falling edge
    assign event_raw = power_on_pin_mode_fuse ? (pin_low_r && dbnc_r >= DBNC_CYC)
                                              : power_on_pin;       // RULE9
    // Qualify; overvoltage ignored when disabled or not shut down
    assign event_ok = event_raw && qual.uv_ok && !qual.tsd
                    && !(qual.ov_det && qual.ov_en && qual.ov_sdwn_fuse)
                    && !qual.trim_load_failed && !qual.fuse_load_failed
                    && !qual.self_test_failed;                      // RULE10

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= PUS_ST_OFF;
        else
            state_r <= state_nxt;
    end

    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            PUS_ST_OFF:                   // Core biasing
                if (cnt_r >= BIAS_CYC - 1)
                    state_nxt = PUS_ST_FUSE;                        // RULE1
            PUS_ST_FUSE:
                if (cnt_r >= FUSE_CYC - 1)
                    state_nxt = PUS_ST_LPOFF;                       // RULE7
            PUS_ST_LPOFF:
                if (event_ok)
                    state_nxt = PUS_ST_STEST;                       // RULE5
            PUS_ST_STEST:
                if (cnt_r >= STEST_CYC - 1)
                    state_nxt = PUS_ST_SEQ;                         // RULE2 RULE3
            PUS_ST_SEQ:                   // Leave once the last slot has had its time base
                if (tick && (slot_r > last_slot || slot_r == 8'h00)) // Wrap ends code 0xff
                    state_nxt = PUS_ST_RUN;                         // RULE16 RULE17
            PUS_ST_RUN:
                if (stby_req_r)
                    state_nxt = PUS_ST_STBY;
            PUS_ST_STBY:
                if (!stby_req_r)
                    state_nxt = stby_was_on_r ? PUS_ST_SEQ : PUS_ST_RUN; // RULE18
            default:
                state_nxt = PUS_ST_OFF;
        endcase
    end

    // ==========================================================
    // Phase timer, cleared on each state change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= '0;
        else if (state_nxt != state_r)
            cnt_r <= '0;
        else if (cnt_r != 32'hffff_ffff)
            cnt_r <= cnt_r + 32'h1;
    end

    // Self-test status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stest_ok_r <= 1'b0;
        else if (state_r == PUS_ST_STEST && state_nxt == PUS_ST_SEQ)
            stest_ok_r <= 1'b1;
    end

    // ==========================================================
    // Slot timer: slot 1 ticks on first sequencing cycle, later ones per base
    assign tick = (state_r == PUS_ST_SEQ) && (slot_r == 8'h01 || tb_cnt_r >= tb_cyc - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_r   <= 8'h01;
            tb_cnt_r <= '0;
        end
        else if (state_r != PUS_ST_SEQ)
        begin
            slot_r   <= 8'h01;
            tb_cnt_r <= '0;
        end
        else if (tick)
        begin
            slot_r   <= slot_r + 8'h01;   // RULE14 RULE23
            tb_cnt_r <= '0;
        end
        else
            tb_cnt_r <= tb_cnt_r + 32'h1;
    end

    // ==========================================================
    // Sequenced outputs
    // Rail units also drop in standby, so that leaving it re-sequences them
    pus_slot_out u_sw (.pclk(pclk), .presetn(presetn),
        .slot_clr(state_r == PUS_ST_LPOFF || state_r == PUS_ST_STBY), .slot_tick(tick),
        .slot_now(slot_r), .slot_code(switcher_slot_r), .out_on(sw_en_i));
    pus_slot_out u_ldo (.pclk(pclk), .presetn(presetn),
        .slot_clr(state_r == PUS_ST_LPOFF || state_r == PUS_ST_STBY), .slot_tick(tick),
        .slot_now(slot_r), .slot_code(linear_regulator_slot_r), .out_on(ldo_en_i));
    pus_slot_out u_pg (.pclk(pclk), .presetn(presetn),
        .slot_clr(state_r == PUS_ST_LPOFF), .slot_tick(tick), .slot_now(slot_r),
        .slot_code(power_good_output_slot_r), .out_on(pg_i));
    pus_slot_out u_rst (.pclk(pclk), .presetn(presetn),
        .slot_clr(state_r == PUS_ST_LPOFF), .slot_tick(tick), .slot_now(slot_r),
        .slot_code(host_reset_slot_r), .out_on(rst_i));

    // Unslotted host reset released on run entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rst_rel_r <= 1'b0;
        else if (state_r == PUS_ST_LPOFF)
            rst_rel_r <= 1'b0;
        else if (host_reset_slot_r == 8'h00 && state_nxt == PUS_ST_RUN)
            rst_rel_r <= 1'b1;            // RULE15 RULE16
    end

    // Output registers; rails cut while in standby
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_en               <= 1'b0;
            ldo_en              <= 1'b0;
            power_good_output   <= 1'b0;
            host_reset_output_n <= 1'b0;
        end
        else
        begin
            sw_en               <= sw_en_i && state_r != PUS_ST_STBY;
            ldo_en              <= ldo_en_i && state_r != PUS_ST_STBY;
            power_good_output   <= pg_i;
            host_reset_output_n <= rst_i || rst_rel_r;
        end
    end

    // Standby cut rails, so exit must re-sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stby_was_on_r <= 1'b0;
        else if (state_r == PUS_ST_RUN)
            stby_was_on_r <= sw_en_i || ldo_en_i;
    end

    // ==========================================================
    // Completion flag, set wins over software clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seq_done <= 1'b0;
        else if (state_r != PUS_ST_RUN && state_nxt == PUS_ST_RUN)
            seq_done <= 1'b1;             // RULE17 RULE19
        else if (wr_en && paddr == `PUS_STAT_OFF && pwdata[`PUS_STAT_DONE])
            seq_done <= 1'b0;
    end

    // ==========================================================
    // APB: zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign pslverr = psel && penable && paddr > `PUS_STBY_OFF;

    // Control bits; low-power-off written only in run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_power_off_r <= 1'b0;      // RULE6
            stby_req_r      <= 1'b0;
        end
        else if (wr_en && paddr == `PUS_CTRL_OFF)
        begin
            if (state_r == PUS_ST_RUN)
                low_power_off_r <= pwdata[`PUS_CTRL_LPOFF]; // RULE8
            stby_req_r <= pwdata[`PUS_CTRL_STBY];
        end
    end

    // Time base and slots: reload in off modes, writable while on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sequencer_time_base_r    <= 2'h0;
            switcher_slot_r          <= 8'h00;
            linear_regulator_slot_r  <= 8'h00;
            power_good_output_slot_r <= 8'h00;
            host_reset_slot_r        <= 8'h00;
        end
        else if (state_r == PUS_ST_FUSE || state_r == PUS_ST_LPOFF)
        begin
            sequencer_time_base_r    <= fuse.tbase;          // RULE11 RULE22
            switcher_slot_r          <= fuse.sw_slot;        // RULE21
            linear_regulator_slot_r  <= fuse.ldo_slot;
            power_good_output_slot_r <= fuse.pg_slot;
            host_reset_slot_r        <= fuse.rst_slot;
        end
        else if (wr_en && (state_r == PUS_ST_RUN || state_r == PUS_ST_STBY))
        begin
            if (paddr == `PUS_TBASE_OFF)
                sequencer_time_base_r <= pwdata[1:0];        // RULE11
            if (paddr == `PUS_SLOT_OFF)
            begin
                switcher_slot_r          <= pwdata[7:0];     // RULE21
                linear_regulator_slot_r  <= pwdata[15:8];
                power_good_output_slot_r <= pwdata[23:16];
                host_reset_slot_r        <= pwdata[31:24];
            end
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `PUS_CTRL_OFF:  prdata <= {30'h0, stby_req_r, low_power_off_r};
                `PUS_STAT_OFF:  prdata <= {29'h0, stest_ok_r,
                                           state_r == PUS_ST_RUN, seq_done};
                `PUS_TBASE_OFF: prdata <= {30'h0, sequencer_time_base_r};
                `PUS_SLOT_OFF:  prdata <= {host_reset_slot_r, power_good_output_slot_r,
                                           linear_regulator_slot_r, switcher_slot_r};
                `PUS_STBY_OFF:  prdata <= {29'h0, state_r};
                default:        prdata <= '0;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_bias_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        state_r == PUS_ST_OFF |-> cnt_r < BIAS_CYC) else $error("bias overrun");
    a_first_slot: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        state_r == PUS_ST_STEST && state_nxt == PUS_ST_SEQ |=> tick)
        else $error("first slot late");
    a_zero_slot: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        switcher_slot_r == 8'h00 && state_r == PUS_ST_SEQ |=> !sw_en_i)
        else $error("zero slot enabled");
    a_done_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        state_r != PUS_ST_RUN && state_nxt == PUS_ST_RUN |=> seq_done)
        else $error("done missing");
    a_lpoff_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        state_r != PUS_ST_RUN |=> $stable(low_power_off_r))
        else $error("low_power_off_state changed");
    a_event_qual: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        state_r == PUS_ST_LPOFF && qual.tsd |=> state_r == PUS_ST_LPOFF)
        else $error("event in shutdown");
    a_reload: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
        state_r == PUS_ST_LPOFF |=> switcher_slot_r == $past(fuse.sw_slot))
        else $error("no reload");
    a_rst_rel: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
        host_reset_slot_r == 8'h00 && state_r != PUS_ST_RUN && state_nxt == PUS_ST_RUN
        |=> ##1 host_reset_output_n) else $error("reset held");

endmodule : pus_seq

// >>> rtl/pus_slot_out.sv
`timescale 1ns/1ps
// One sequenced output: turns on when the running slot count reaches its code.
// Assumes the caller clears slot_clr between sequences.
module pus_slot_out
    import pus_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Sequencer timing
    input  wire logic       slot_clr,     // Drop output
    input  wire logic       slot_tick,    // Slot boundary pulse
    input  wire logic [7:0] slot_now,     // Slot code being processed
    input  wire logic [7:0] slot_code,    // This output's code
    // Output
    output logic            out_on
);

    // ==========================================================
    // Enable on matching slot; code 0 never matches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_on <= 1'b0;
        else if (slot_clr)
            out_on <= 1'b0;
        else if (slot_tick && slot_code != 8'h00 && slot_code == slot_now) // RULE13 RULE23
            out_on <= 1'b1;
    end

endmodule : pus_slot_out
